// ### pws_pkg.sv
/*
 * Constants for the position window switch: register map, field
 * positions, reset values and state codes.
 * Assumes a 32-bit APB master and position words in user units.
 */
// Overview of operation
// RULE1: Select motor feedback, command or master position.
// RULE2: Active while on point < position < off point.
// RULE3: Positive travel: on at on point, off at off.
// RULE4: Negative travel: on at off point, off past on.
// RULE5: Either-direction qualifier ignores motion direction.
// RULE6: Positive-only qualifier activates only moving positive.
// RULE7: Negative-only qualifier activates only moving negative.
// RULE8: Rotary enable chooses wrapped or absolute compare.
// RULE9: Window recurs at every multiple of wrap distance.
// RULE10: Folded position ranges from zero to wrap distance.
// RULE11: Inverted window active outside span when on > off.
// RULE12: Inverted window stays off until on point reached.
// RULE13: Software puts more negative value in on point.
// RULE14: Direction from sign of sample difference, held on zero.
// RULE15: Output updated per sample, cleared by reset.
package pws_pkg;
    localparam int ADDR_W = 8;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_ON = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_OFF = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_WRAP = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_FOLDED = 8'h14;
    // Control field positions
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_DIR_LSB = 2;
    localparam int CTRL_ROT_BIT = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    // Status field positions
    localparam int STAT_OUT_BIT = 0;
    localparam int STAT_POS_BIT = 1;
    localparam int STAT_ARMED_BIT = 2;
    localparam int STAT_TRACK_BIT = 3;
    // Position sources
    typedef enum logic [1:0] {
        PWS_SRC_FEEDBACK = 2'b00,
        PWS_SRC_COMMAND = 2'b01,
        PWS_SRC_MASTER = 2'b10
    } pws_src_t;
    // Direction qualifier
    typedef enum logic [1:0] {
        PWS_DIR_BOTH = 2'b00,
        PWS_DIR_PLUS = 2'b01,
        PWS_DIR_MINUS = 2'b10
    } pws_dir_t;
    // Sample processing states
    typedef enum logic [1:0] {
        PWS_ST_IDLE = 2'b00,
        PWS_ST_FOLD = 2'b01,
        PWS_ST_CMP = 2'b10
    } pws_state_t;
endpackage

// ### pws_switch.sv
/*
 * Position window switch with APB register access.
 * Compares one selected position against an on/off window, with a
 * direction qualifier and optional rotary rollover folding.
 * Assumes position words and their sample strobe come from logic on
 * pclk, so they are used without synchronisers.
 */
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
module pws_switch #(
    parameter int POS_W = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pws_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic signed [POS_W-1:0] motor_feedback_position,
    input wire logic signed [POS_W-1:0] motor_commanded_position,
    input wire logic signed [POS_W-1:0] master_feedback_position,
    input wire logic position_valid,
    output logic switch_output_active
);
    // Configuration
    logic [1:0] src_sel;
    logic [1:0] dir_qual;
    logic rotary_en;
    logic signed [POS_W-1:0] window_on_point;
    logic signed [POS_W-1:0] window_off_point;
    logic signed [POS_W-1:0] wrap_distance;
    // Tracking state
    pws_pkg::pws_state_t state;
    logic signed [POS_W-1:0] prev_pos;
    logic signed [POS_W-1:0] work_pos;
    logic signed [POS_W-1:0] folded_pos;
    logic tracking;
    logic moving_pos;
    logic armed;
    // Bus decode
    logic bus_access;
    logic bus_write;
    logic addr_ok;
    logic cfg_write;
    logic signed [POS_W-1:0] sel_pos;
    logic signed [POS_W-1:0] delta;
    logic wrap_on;
    logic inverted;
    logic in_window;
    logic dir_allow;
    logic reach_on;

    assign bus_access = psel && penable && pready;
    assign bus_write = bus_access && pwrite;
    assign addr_ok = (paddr == pws_pkg::OFS_CTRL)
        || (paddr == pws_pkg::OFS_ON)
        || (paddr == pws_pkg::OFS_OFF)
        || (paddr == pws_pkg::OFS_WRAP)
        || (paddr == pws_pkg::OFS_STATUS)
        || (paddr == pws_pkg::OFS_FOLDED);
    // Any write to a setting restarts tracking and disarms
    assign cfg_write = bus_write && addr_ok
        && (paddr != pws_pkg::OFS_STATUS)
        && (paddr != pws_pkg::OFS_FOLDED);

    // Source selection
    always_comb begin
        unique case (src_sel)
            pws_pkg::PWS_SRC_COMMAND: sel_pos = motor_commanded_position; // RULE1
            pws_pkg::PWS_SRC_MASTER: sel_pos = master_feedback_position; // RULE1
            default: sel_pos = motor_feedback_position; // RULE1
        endcase
    end

    assign delta = sel_pos - prev_pos;
    // A non-positive wrap distance cannot fold; treat as absolute
    assign wrap_on = rotary_en && (wrap_distance > 0); // RULE8
    assign inverted = wrap_on && (window_on_point > window_off_point);

    // Window compare on the folded or absolute position
    always_comb begin
        if (inverted) begin
            in_window = (work_pos > window_on_point)
                || (work_pos < window_off_point); // RULE11
        end else begin
            in_window = (work_pos > window_on_point)
                && (work_pos < window_off_point); // RULE2 RULE3 RULE4
        end
    end

    // Direction qualifier
    always_comb begin
        unique case (dir_qual)
            pws_pkg::PWS_DIR_PLUS: dir_allow = moving_pos; // RULE6
            pws_pkg::PWS_DIR_MINUS: dir_allow = !moving_pos; // RULE7
            default: dir_allow = 1'b1; // RULE5
        endcase
    end

    assign reach_on = work_pos >= window_on_point;

    // APB handshake: one wait state, answer registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addr_ok;
        end
    end

    // Read data, captured just before the access completes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            prdata <= 32'h0000_0000;
            unique case (paddr)
                pws_pkg::OFS_CTRL: begin
                    prdata[pws_pkg::CTRL_SRC_LSB +: 2] <= src_sel;
                    prdata[pws_pkg::CTRL_DIR_LSB +: 2] <= dir_qual;
                    prdata[pws_pkg::CTRL_ROT_BIT] <= rotary_en;
                end
                pws_pkg::OFS_ON: prdata <= 32'(window_on_point);
                pws_pkg::OFS_OFF: prdata <= 32'(window_off_point);
                pws_pkg::OFS_WRAP: prdata <= 32'(wrap_distance);
                pws_pkg::OFS_STATUS: begin
                    prdata[pws_pkg::STAT_OUT_BIT] <= switch_output_active;
                    prdata[pws_pkg::STAT_POS_BIT] <= moving_pos;
                    prdata[pws_pkg::STAT_ARMED_BIT] <= armed;
                    prdata[pws_pkg::STAT_TRACK_BIT] <= tracking;
                end
                pws_pkg::OFS_FOLDED: prdata <= 32'(folded_pos);
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_sel <= pws_pkg::CTRL_RESET[pws_pkg::CTRL_SRC_LSB +: 2];
            dir_qual <= pws_pkg::CTRL_RESET[pws_pkg::CTRL_DIR_LSB +: 2];
            rotary_en <= pws_pkg::CTRL_RESET[pws_pkg::CTRL_ROT_BIT];
        end else if (bus_write && paddr == pws_pkg::OFS_CTRL) begin
            src_sel <= pwdata[pws_pkg::CTRL_SRC_LSB +: 2]; // RULE1
            dir_qual <= pwdata[pws_pkg::CTRL_DIR_LSB +: 2];
            rotary_en <= pwdata[pws_pkg::CTRL_ROT_BIT]; // RULE8
        end
    end

    // Window and wrap settings; ordering of on/off is software's job
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            window_on_point <= '0;
            window_off_point <= '0;
            wrap_distance <= '0;
        end else if (bus_write) begin
            if (paddr == pws_pkg::OFS_ON) begin
                window_on_point <= POS_W'(pwdata); // RULE13
            end
            if (paddr == pws_pkg::OFS_OFF) begin
                window_off_point <= POS_W'(pwdata); // RULE13
            end
            if (paddr == pws_pkg::OFS_WRAP) begin
                wrap_distance <= POS_W'(pwdata);
            end
        end
    end

    // Sample sequencer: latch, fold, compare
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= pws_pkg::PWS_ST_IDLE;
            work_pos <= '0;
        end else begin
            unique case (state)
                pws_pkg::PWS_ST_IDLE: begin
                    if (position_valid && !cfg_write) begin
                        if (wrap_on && tracking) begin
                            // Incremental fold keeps the loop short
                            work_pos <= folded_pos + delta; // RULE9
                        end else begin
                            work_pos <= sel_pos;
                        end
                        state <= wrap_on ? pws_pkg::PWS_ST_FOLD
                                         : pws_pkg::PWS_ST_CMP;
                    end
                end
                pws_pkg::PWS_ST_FOLD: begin
                    // One wrap step a cycle; large jumps take longer
                    if (cfg_write) begin
                        state <= pws_pkg::PWS_ST_IDLE;
                    end else if (work_pos < 0) begin
                        work_pos <= work_pos + wrap_distance; // RULE10
                    end else if (work_pos >= wrap_distance) begin
                        work_pos <= work_pos - wrap_distance; // RULE10
                    end else begin
                        state <= pws_pkg::PWS_ST_CMP;
                    end
                end
                pws_pkg::PWS_ST_CMP: begin
                    state <= pws_pkg::PWS_ST_IDLE;
                end
                default: state <= pws_pkg::PWS_ST_IDLE;
            endcase
        end
    end

    // Previous position and motion direction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_pos <= '0;
            moving_pos <= 1'b1;
        end else if (state == pws_pkg::PWS_ST_IDLE && position_valid
                     && !cfg_write) begin
            prev_pos <= sel_pos;
            if (tracking && delta > 0) begin
                moving_pos <= 1'b1; // RULE14
            end else if (tracking && delta < 0) begin
                moving_pos <= 1'b0; // RULE14
            end
        end
    end

    // Folded position and tracking flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            folded_pos <= '0;
            tracking <= 1'b0;
        end else if (cfg_write) begin
            tracking <= 1'b0;
        end else if (state == pws_pkg::PWS_ST_CMP) begin
            folded_pos <= work_pos;
            tracking <= 1'b1;
        end
    end

    // Arm for the inverted window once the on point is reached
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed <= 1'b0; // RULE12
        end else if (cfg_write) begin
            armed <= 1'b0; // RULE12
        end else if (state == pws_pkg::PWS_ST_CMP && reach_on) begin
            armed <= 1'b1; // RULE12
        end
    end

    // Switch output, one update per sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            switch_output_active <= 1'b0; // RULE15
        end else if (cfg_write) begin
            switch_output_active <= 1'b0;
        end else if (state == pws_pkg::PWS_ST_CMP) begin
            switch_output_active <= in_window && dir_allow
                && (!inverted || armed || reach_on); // RULE15 RULE12
        end
    end
endmodule // pws_switch

// ### pws_switch_sva.sv
/* Checker for the position window switch: APB timing, error flag,
   window output of absolute compares.
   Assumes it is bound to pws_switch and sees only its ports. */
`timescale 1ns/100ps
module pws_switch_chk #(
    parameter int POS_W = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pws_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic signed [POS_W-1:0] motor_feedback_position,
    input wire logic signed [POS_W-1:0] motor_commanded_position,
    input wire logic signed [POS_W-1:0] master_feedback_position,
    input wire logic position_valid,
    input wire logic switch_output_active
);
    logic [4:0] ctrl;
    logic signed [POS_W-1:0] on_pt, off_pt, prev, pos;
    logic seen, up, up_now, exp_now, wr_cfg;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadow config; a write forgets the last position but keeps the direction
    assign wr_cfg = psel && penable && pready && pwrite
        && paddr[1:0] == 2'h0 && paddr < 8'h10;
    assign pos = ctrl[1:0] == 2'h1 ? motor_commanded_position :
        ctrl[1:0] == 2'h2 ? master_feedback_position :
        motor_feedback_position;
    // First sample after a write has no reference; direction is held
    assign up_now = seen ? (pos > prev || (pos == prev && up)) : up;
    assign exp_now = on_pt < pos && pos < off_pt &&
        (ctrl[3:2] == 2'h1 ? up_now : ctrl[3:2] != 2'h2 || !up_now);
    // Shadow registers follow completed writes and taken samples
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= 5'h00;
            on_pt <= '0;
            off_pt <= '0;
            prev <= '0;
            seen <= 1'b0;
            up <= 1'b1;
        end else if (wr_cfg) begin
            seen <= 1'b0;
            case (paddr)
                pws_pkg::OFS_CTRL: ctrl <= pwdata[4:0];
                pws_pkg::OFS_ON: on_pt <= pwdata[POS_W-1:0];
                pws_pkg::OFS_OFF: off_pt <= pwdata[POS_W-1:0];
                default: ;
            endcase
        end else if (position_valid) begin
            seen <= 1'b1;
            up <= up_now;
            prev <= pos;
        end
    end
    chk_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late in access phase");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held over two cycles");
    chk_setup_quiet: assert property (psel && !penable |-> !pready)
        else $error("pready during setup");
    chk_err_map: assert property (pready |->
        pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h14))
        else $error("pslverr does not match address map");
    chk_reset_quiet: assert property ($rose(presetn) |->
        !switch_output_active ##1 !switch_output_active)
        else $error("output active right after reset");
    chk_window_abs: assert property (position_valid && !ctrl[4] |->
        ##2 switch_output_active == $past(exp_now, 2))
        else $error("absolute window output wrong");
    chk_write_clears: assert property (wr_cfg |=> !switch_output_active)
        else $error("config write left output on");
    chk_rise_cause: assert property ($rose(switch_output_active) |->
        $past(position_valid, 2) || ctrl[4])
        else $error("output rose without a sample");
    cover property ($rose(switch_output_active));
    cover property (pready && pslverr);
    cover property (position_valid && ctrl[4]);
endmodule // pws_switch_chk
bind pws_switch pws_switch_chk #(.POS_W(POS_W)) u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .motor_feedback_position(motor_feedback_position),
    .motor_commanded_position(motor_commanded_position),
    .master_feedback_position(master_feedback_position),
    .position_valid(position_valid),
    .switch_output_active(switch_output_active));

// ### pws_motion_model.sv
/* Motion controller model: holds three position words and pulses
   position_valid once per requested sample.
   Assumes the bench raises go for one cycle per sample. */
`timescale 1ns/100ps
module pws_motion_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic signed [31:0] next_fb,
    input wire logic signed [31:0] next_cmd,
    input wire logic signed [31:0] next_mst,
    output logic signed [31:0] motor_feedback_position,
    output logic signed [31:0] motor_commanded_position,
    output logic signed [31:0] master_feedback_position,
    output logic position_valid
);
    // Positions are levels; they stay put between samples
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            position_valid <= 1'b0;
            motor_feedback_position <= 32'sh0000_0000;
            motor_commanded_position <= 32'sh0000_0000;
            master_feedback_position <= 32'sh0000_0000;
        end else begin
            position_valid <= go;
            if (go) begin
                motor_feedback_position <= next_fb;
                motor_commanded_position <= next_cmd;
                master_feedback_position <= next_mst;
            end
        end
    end
endmodule // pws_motion_model

// ### test_programmable_limit_switch.sv
/* Self-checking bench for the position window switch.
   Assumes pws_switch, its checker and the motion model are compiled. */
`timescale 1ns/100ps
module test_programmable_limit_switch;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, position_valid, out, e, up;
    logic signed [31:0] fb, cmd, mst, nfb = 0, ncmd = 0, nmst = 0;
    logic signed [31:0] on, off, p, prev;
    logic signed [31:0] tp [12] = '{32'sh5F, 32'sh64, 32'sh1C7, 32'sh1CC,
        32'sh32F, 32'sh14, 32'shC8, 32'sh136, 32'sh172, 32'shC8, 32'sh1C7,
        32'sh5F};
    logic [11:0] te = 12'h995;
    int error_cnt = 0;
    int compares = 0;
    int first;
    always #5 pclk = ~pclk;
    pws_switch u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .motor_feedback_position(fb), .motor_commanded_position(cmd),
        .master_feedback_position(mst), .position_valid(position_valid),
        .switch_output_active(out));
    pws_motion_model u_motion (.pclk(pclk), .presetn(presetn), .go(go),
        .next_fb(nfb), .next_cmd(ncmd), .next_mst(nmst),
        .motor_feedback_position(fb), .motor_commanded_position(cmd),
        .master_feedback_position(mst), .position_valid(position_valid));
    task automatic stop_test;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic x);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            stop_test();
        end
        r = prdata;
        x = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q, e);
    endtask
    // Unselected sources sit far outside any window used here
    task automatic samp(input logic signed [31:0] v, input logic [1:0] s,
        input logic exp);
        @(posedge pclk);
        nfb <= s == 2'h0 ? v : 32'sh1F4 - v;
        ncmd <= s == 2'h1 ? v : 32'sh1F4 - v;
        nmst <= s == 2'h2 ? v : 32'sh1F4 - v;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (20) @(posedge pclk);
        check({31'h0, out}, {31'h0, exp});
    endtask
    function automatic logic exp_win(input logic signed [31:0] v, lo, hi,
        input logic [1:0] d, input logic u);
        return lo < v && v < hi && (d == 2'h1 ? u : d != 2'h2 || !u);
    endfunction
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        stop_test();
    end
    initial begin
        void'($urandom(45));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 16; a += 4) begin
            apb(1'b0, 8'(a), 32'h0, q, e);
            check(q, 32'h0);
        end
        apb(1'b0, 8'h18, 32'h0, q, e);
        check({q[30:0], e}, 32'h1);
        // Every source and qualifier, exact edges included
        up = 1'b1;
        for (int s = 0; s < 3; s++) begin
            for (int d = 0; d < 4; d++) begin
                on = -32'sh64;
                off = 32'sh20 + 32'($urandom_range(120));
                wr(pws_pkg::OFS_CTRL, {28'h0, d[1:0], s[1:0]});
                wr(pws_pkg::OFS_ON, on);
                wr(pws_pkg::OFS_OFF, off);
                first = 1;
                for (int k = 0; k < 8; k++) begin
                    p = 32'($urandom_range(400)) - 32'shC8;
                    p = k == 2 ? on : k == 5 ? off : p;
                    // Direction is held on the first sample after a write
                    up = first != 0 ? up : (p > prev || (p == prev && up));
                    samp(p, s[1:0], exp_win(p, on, off, d[1:0], up));
                    prev = p;
                    first = 0;
                end
            end
        end
        // Rotary, inverted rotary, then absolute with wrap still set
        wr(pws_pkg::OFS_CTRL, 32'h10);
        wr(pws_pkg::OFS_WRAP, 32'h168);
        wr(pws_pkg::OFS_ON, 32'h5A);
        wr(pws_pkg::OFS_OFF, 32'h64);
        for (int i = 0; i < 12; i++) begin
            if (i == 5) begin
                wr(pws_pkg::OFS_ON, 32'h12C);
                wr(pws_pkg::OFS_OFF, 32'h3C);
            end
            if (i == 10) begin
                wr(pws_pkg::OFS_CTRL, 32'h0);
                wr(pws_pkg::OFS_ON, 32'h5A);
                wr(pws_pkg::OFS_OFF, 32'h64);
            end
            samp(tp[i], 2'h0, te[i]);
            if (i == 4) begin
                apb(1'b0, pws_pkg::OFS_FOLDED, 32'h0, q, e);
                check(q, 32'h5F);
            end
        end
        wr(pws_pkg::OFS_STATUS, 32'h0);
        apb(1'b0, pws_pkg::OFS_STATUS, 32'h0, q, e);
        check({31'h0, q[0]}, 32'h1);
        check({30'h0, q[3], q[1]}, 32'h2);
        stop_test();
    end
endmodule // test_programmable_limit_switch
